// >>> shared/fesb_pkg.sv
// Purpose: constants for the flash command sequencer host
// Assumes: word addressing on a 16-bit parallel flash bus
// Notes: byte-mode addresses are selected in the sequence table
// ****************************************************************
// command words and addresses
// ****************************************************************
package fesb_pkg;
  localparam logic [15:0] D_UNLK1 = 16'h00AA;
  localparam logic [15:0] D_UNLK2 = 16'h0055;
  localparam logic [15:0] D_SETUP = 16'h0080;
  localparam logic [15:0] D_CHIP = 16'h0010;
  localparam logic [15:0] D_SUSP = 16'h00B0;
  localparam logic [15:0] D_RESUME = 16'h0030;
  localparam logic [15:0] D_BYPASS = 16'h0020;
  localparam logic [15:0] D_PGM = 16'h00A0;
  localparam logic [15:0] D_BEXIT1 = 16'h0090;
  localparam logic [15:0] D_BEXIT2 = 16'h0000;
  localparam logic [15:0] D_RESET = 16'h00F0;
  localparam logic [11:0] A_W555 = 12'h555;
  localparam logic [11:0] A_W2AA = 12'h2AA;
  localparam logic [11:0] A_B_AAA = 12'hAAA;
  localparam logic [11:0] A_B_555 = 12'h555;
  // bus write strobe timing, in system clocks
  localparam logic [3:0] WE_LOW_CYC = 4'h4;
  localparam logic [3:0] WE_GAP_CYC = 4'h4;
  // command codes of the user port
  typedef enum logic [3:0] {
    FESB_CMD_CHIP_ERASE = 4'h0,
    FESB_CMD_ERS_SUSP = 4'h1,
    FESB_CMD_ERS_RESUME = 4'h2,
    FESB_CMD_PGM_SUSP = 4'h3,
    FESB_CMD_PGM_RESUME = 4'h4,
    FESB_CMD_BYP_ENTER = 4'h5,
    FESB_CMD_BYP_PGM = 4'h6,
    FESB_CMD_BYP_EXIT = 4'h7,
    FESB_CMD_RESET3 = 4'h8
  } fesb_cmd_t;
endpackage : fesb_pkg

// >>> src/fesb_host.sv
// Purpose: host-side command sequencer driving a parallel NOR flash
// Assumes: one command at a time; the flash bus is write-only here
// Notes: tracks bypass, suspend and accel state as the device does
`timescale 1ns/1ps
module fesb_host #(
  parameter int ADDR_W = 24
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic byte_mode,
  input wire logic accel_req,
  input wire logic erase_busy,
  input wire logic prog_busy,
  output logic cmd_ready,
  output logic cmd_refused,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_we_b,
  output logic write_protect_accel_input,
  output logic bypass_mode,
  output logic erase_suspended,
  output logic prog_suspended,
  output logic chip_erase_on
);
  typedef enum logic [4:0] {
    FESB_IDLE = 5'b00001,
    FESB_FETCH = 5'b00010,
    FESB_LOAD = 5'b00100,
    FESB_LOW = 5'b01000,
    FESB_GAP = 5'b10000
  } fesb_state_t;
  fesb_state_t st_r, st_nxt;
  logic [3:0] cmd_r;
  logic [2:0] step_r;
  logic [3:0] tmr_r;
  logic [ADDR_W-1:0] tgt_r;
  logic [15:0] tgtd_r;
  logic [15:0] rom_d;
  logic [11:0] rom_a;
  logic rom_t;
  logic [2:0] rom_len;
  logic [2:0] acc_sync_r;
  logic [1:0] ebusy_sync_r;
  logic [1:0] pbusy_sync_r;
  logic cmd_ok_w;
  logic last_w;
  logic tmr_done_w;
  logic ebusy_w;
  logic pbusy_w;
  logic acc_on_w;
  logic [3:0] acc_uses_r;
  // accel uses allowed between resets, counted for the whole array
  localparam logic [3:0] ACC_USE_MAX = 4'hA;
  // busy and accel inputs cross from outside: two flops for each busy input, three for accel
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_sync_r <= 3'b000;
      ebusy_sync_r <= 2'b00;
      pbusy_sync_r <= 2'b00;
    end else begin
      acc_sync_r <= {acc_sync_r[1:0], accel_req};
      ebusy_sync_r <= {ebusy_sync_r[0], erase_busy};
      pbusy_sync_r <= {pbusy_sync_r[0], prog_busy};
    end
  end
  assign ebusy_w = ebusy_sync_r[1];
  assign pbusy_w = pbusy_sync_r[1];
  // a new accel use starts only while uses remain
  assign acc_on_w = acc_sync_r[2] &&
    (write_protect_accel_input || acc_uses_r != ACC_USE_MAX);
  // ****************************************************************
  // command legality against tracked device state
  // ****************************************************************
  always_comb begin
    cmd_ok_w = 1'b0;
    case (cmd_code)
      fesb_pkg::FESB_CMD_CHIP_ERASE:
        cmd_ok_w = !erase_suspended && !prog_suspended;
      fesb_pkg::FESB_CMD_ERS_SUSP:
        cmd_ok_w = ebusy_w && !chip_erase_on && !erase_suspended;
      fesb_pkg::FESB_CMD_ERS_RESUME:
        cmd_ok_w = erase_suspended && !prog_suspended;
      fesb_pkg::FESB_CMD_PGM_SUSP:
        cmd_ok_w = pbusy_w && !prog_suspended;
      fesb_pkg::FESB_CMD_PGM_RESUME:
        cmd_ok_w = prog_suspended;
      fesb_pkg::FESB_CMD_BYP_ENTER:
        cmd_ok_w = !bypass_mode;
      fesb_pkg::FESB_CMD_BYP_PGM:
        cmd_ok_w = bypass_mode;
      fesb_pkg::FESB_CMD_BYP_EXIT:
        cmd_ok_w = bypass_mode && !acc_on_w;
      fesb_pkg::FESB_CMD_RESET3:
        cmd_ok_w = 1'b1;
      default: cmd_ok_w = 1'b0;
    endcase
  end
  // chip erase in flight blocks everything
  logic take_w;
  assign take_w = cmd_valid && cmd_ready && cmd_ok_w && !chip_erase_on;
  assign last_w = (step_r + 3'h1) >= rom_len;
  assign tmr_done_w = (tmr_r == 4'h1);
  fesb_seq_rom fesb_seq_rom_i (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .cmd(cmd_r),
    .step(step_r),
    .byte_mode(byte_mode),
    .rd_data(rom_d),
    .rd_addr(rom_a),
    .rd_use_tgt(rom_t),
    .rd_len(rom_len)
  );
  // next state; fetch lets the table's registered read settle
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      FESB_IDLE: if (take_w) st_nxt = FESB_FETCH;
      FESB_FETCH: st_nxt = FESB_LOAD;
      FESB_LOAD: st_nxt = FESB_LOW;
      FESB_LOW: if (tmr_done_w) st_nxt = FESB_GAP;
      FESB_GAP: if (tmr_done_w) st_nxt = last_w ? FESB_IDLE : FESB_FETCH;
      default: st_nxt = FESB_IDLE;
    endcase
  end
  // ****************************************************************
  // write cycle sequencer
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= FESB_IDLE;
      cmd_r <= 4'h0;
      step_r <= 3'h0;
      tmr_r <= 4'h0;
      tgt_r <= '0;
      tgtd_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      if (take_w) begin
        cmd_r <= cmd_code;
        step_r <= 3'h0;
        tgt_r <= cmd_addr;
        tgtd_r <= cmd_data;
      end
      if (st_r == FESB_LOAD) tmr_r <= fesb_pkg::WE_LOW_CYC;
      else if (st_r == FESB_LOW && tmr_done_w)
        tmr_r <= fesb_pkg::WE_GAP_CYC;
      else if (tmr_r != 4'h0) tmr_r <= tmr_r - 4'h1;
      if (st_r == FESB_GAP && tmr_done_w) step_r <= step_r + 3'h1;
    end
  end
  // bus pins, all registered
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_addr <= '0;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_we_b <= 1'b1;
      cmd_ready <= 1'b0;
      cmd_refused <= 1'b0;
    end else begin
      cmd_ready <= (st_nxt == FESB_IDLE) && !take_w;
      cmd_refused <= cmd_valid && cmd_ready && !take_w;
      if (st_r == FESB_LOAD) begin
        flash_addr <= rom_t ? tgt_r : ADDR_W'(rom_a);
        flash_dq_out <= rom_t ? tgtd_r : rom_d;
        flash_dq_oe <= 1'b1;
        flash_we_b <= 1'b0;
      end else if (st_r == FESB_LOW && tmr_done_w) begin
        flash_we_b <= 1'b1;
      end else if (st_r == FESB_GAP && tmr_done_w) begin
        flash_dq_oe <= 1'b0;
      end
    end
  end
  // ****************************************************************
  // device mode tracking
  // ****************************************************************
  logic done_w;
  assign done_w = (st_r == FESB_GAP) && tmr_done_w && last_w;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bypass_mode <= 1'b0;
      erase_suspended <= 1'b0;
      prog_suspended <= 1'b0;
      chip_erase_on <= 1'b0;
      write_protect_accel_input <= 1'b0;
      acc_uses_r <= 4'h0;
    end else begin
      write_protect_accel_input <= acc_on_w;
      if (acc_on_w && !write_protect_accel_input)
        acc_uses_r <= acc_uses_r + 4'h1;
      if (write_protect_accel_input && !acc_on_w) bypass_mode <= 1'b0;
      if (chip_erase_on && !ebusy_w && st_r == FESB_IDLE)
        chip_erase_on <= 1'b0;
      if (done_w) begin
        case (cmd_r)
          fesb_pkg::FESB_CMD_CHIP_ERASE: chip_erase_on <= 1'b1;
          fesb_pkg::FESB_CMD_ERS_SUSP: erase_suspended <= 1'b1;
          fesb_pkg::FESB_CMD_ERS_RESUME: erase_suspended <= 1'b0;
          fesb_pkg::FESB_CMD_PGM_SUSP: prog_suspended <= 1'b1;
          fesb_pkg::FESB_CMD_PGM_RESUME: prog_suspended <= 1'b0;
          fesb_pkg::FESB_CMD_BYP_ENTER: bypass_mode <= 1'b1;
          fesb_pkg::FESB_CMD_BYP_EXIT: bypass_mode <= 1'b0;
          default: ;
        endcase
      end
      if (acc_on_w) bypass_mode <= 1'b1;
    end
  end
  // ****************************************************************
  // checks
  // ****************************************************************
  a_we_low_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(flash_we_b) |-> !flash_we_b [*4] ##1 flash_we_b)
    else $error("write strobe low length wrong");
  a_oe_with_we: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !flash_we_b |-> flash_dq_oe)
    else $error("data not driven under write strobe");
  a_no_susp_chip: assert property (@(posedge sys_clk) disable iff (!rst_b)
    chip_erase_on |-> flash_we_b)
    else $error("write strobe during chip erase");
  a_resume_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    done_w && cmd_r == fesb_pkg::FESB_CMD_ERS_RESUME |=> !erase_suspended)
    else $error("erase resume left suspend set");
  a_pres_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    done_w && cmd_r == fesb_pkg::FESB_CMD_PGM_RESUME |=> !prog_suspended)
    else $error("program resume left suspend set");
  a_accel_byp: assert property (@(posedge sys_clk) disable iff (!rst_b)
    acc_on_w |=> bypass_mode)
    else $error("accel without bypass");
  a_acc_limit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    acc_uses_r == ACC_USE_MAX && !write_protect_accel_input
    |=> !write_protect_accel_input)
    else $error("accel use beyond limit");
  a_byp_pgm_tgt: assert property (@(posedge sys_clk) disable iff (!rst_b)
    done_w && cmd_r == fesb_pkg::FESB_CMD_BYP_PGM |->
      flash_addr == tgt_r && flash_dq_out == tgtd_r)
    else $error("bypass program data not at target");
  a_refuse_bad: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_valid && cmd_ready && !cmd_ok_w |=> cmd_refused)
    else $error("bad command not refused");
  a_byp_enter: assert property (@(posedge sys_clk) disable iff (!rst_b)
    done_w && cmd_r == fesb_pkg::FESB_CMD_BYP_ENTER |=> bypass_mode)
    else $error("bypass entry not tracked");
  c_chip: cover property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(chip_erase_on));
  c_esusp: cover property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(erase_suspended));
  c_psusp: cover property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(prog_suspended) && erase_suspended);
  c_bypx: cover property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(bypass_mode));
endmodule : fesb_host

// >>> src/fesb_seq_rom.sv
// Purpose: sequence table: word count and cycle contents per command
// Assumes: registered read, one cycle latency
// Notes: address flag 1 selects the caller's target address
`timescale 1ns/1ps
module fesb_seq_rom (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [3:0] cmd,
  input wire logic [2:0] step,
  input wire logic byte_mode,
  output logic [15:0] rd_data,
  output logic [11:0] rd_addr,
  output logic rd_use_tgt,
  output logic [2:0] rd_len
);
  logic [15:0] d_w;
  logic [11:0] a_w;
  logic t_w;
  logic [2:0] l_w;
  logic [11:0] a5_w;
  logic [11:0] a2_w;
  // unlock addresses by bus width
  assign a5_w = byte_mode ? fesb_pkg::A_B_AAA : fesb_pkg::A_W555;
  assign a2_w = byte_mode ? fesb_pkg::A_B_555 : fesb_pkg::A_W2AA;
  // ****************************************************************
  // table decode
  // ****************************************************************
  always_comb begin
    d_w = fesb_pkg::D_SUSP;
    a_w = 12'h000;
    t_w = 1'b0;
    l_w = 3'h1;
    case (cmd)
      fesb_pkg::FESB_CMD_CHIP_ERASE: begin
        l_w = 3'h6; // six cycles
        case (step)
          3'h0, 3'h3: begin d_w = fesb_pkg::D_UNLK1; a_w = a5_w; end
          3'h1, 3'h4: begin d_w = fesb_pkg::D_UNLK2; a_w = a2_w; end
          3'h2: begin d_w = fesb_pkg::D_SETUP; a_w = a5_w; end
          default: begin d_w = fesb_pkg::D_CHIP; a_w = a5_w; end
        endcase
      end
      fesb_pkg::FESB_CMD_ERS_SUSP,
      fesb_pkg::FESB_CMD_PGM_SUSP: d_w = fesb_pkg::D_SUSP;
      fesb_pkg::FESB_CMD_ERS_RESUME,
      fesb_pkg::FESB_CMD_PGM_RESUME: d_w = fesb_pkg::D_RESUME;
      fesb_pkg::FESB_CMD_BYP_ENTER: begin
        l_w = 3'h3;
        case (step)
          3'h0: begin d_w = fesb_pkg::D_UNLK1; a_w = a5_w; end
          3'h1: begin d_w = fesb_pkg::D_UNLK2; a_w = a2_w; end
          default: begin d_w = fesb_pkg::D_BYPASS; a_w = a5_w; end
        endcase
      end
      fesb_pkg::FESB_CMD_BYP_PGM: begin
        l_w = 3'h2; // setup then data at target
        d_w = fesb_pkg::D_PGM;
        t_w = (step != 3'h0);
      end
      fesb_pkg::FESB_CMD_BYP_EXIT: begin
        l_w = 3'h2;
        d_w = (step == 3'h0) ? fesb_pkg::D_BEXIT1 : fesb_pkg::D_BEXIT2;
      end
      fesb_pkg::FESB_CMD_RESET3: begin
        l_w = 3'h3; // full reset form in bypass
        case (step)
          3'h0: begin d_w = fesb_pkg::D_UNLK1; a_w = a5_w; end
          3'h1: begin d_w = fesb_pkg::D_UNLK2; a_w = a2_w; end
          default: begin d_w = fesb_pkg::D_RESET; a_w = a5_w; end
        endcase
      end
      default: l_w = 3'h0;
    endcase
  end
  // registered read data
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 16'h0000;
      rd_addr <= 12'h000;
      rd_use_tgt <= 1'b0;
      rd_len <= 3'h0;
    end else begin
      rd_data <= d_w;
      rd_addr <= a_w;
      rd_use_tgt <= t_w;
      rd_len <= l_w;
    end
  end
endmodule : fesb_seq_rom

// >>> test/fesb_flash_model.sv
// Purpose: behavioural flash device answering the command sequencer
// Assumes: word or byte unlock addresses chosen by byte_mode
// Notes: keeps a ring of the last sixteen bus writes for the bench
`timescale 1ns/1ps
module fesb_flash_model #(
  parameter int CE_CYC = 300,
  parameter int SE_CYC = 1500,
  parameter int PG_CYC = 600,
  parameter int SU_CYC = 150,
  parameter int SW_CYC = 5000
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [23:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_we_b,
  input wire logic write_protect_accel_input,
  input wire logic byte_mode,
  input wire logic sect_erase_go,
  output logic erase_busy,
  output logic prog_busy
);
  // ****************************************************************
  // command decode on each write strobe
  // ****************************************************************
  logic [23:0] log_a [16];
  logic [15:0] log_d [16];
  int log_n, n, etmr, ptmr, sdly, swin;
  logic we_q, byp, x1, setup, chip_on, esusp, psusp, acc_q;
  logic [11:0] a, u1, u2;
  logic [15:0] d;
  assign a = flash_addr[11:0];
  assign d = flash_dq_out;
  assign u1 = byte_mode ? 12'hAAA : 12'h555;
  assign u2 = byte_mode ? 12'h555 : 12'h2AA;
  assign erase_busy = etmr != 0 && !esusp;
  assign prog_busy = ptmr != 0 && !psusp;
  // hardware reset aborts any operation
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {we_q, acc_q} <= 2'h2;
      {byp, x1, setup, chip_on, esusp, psusp} <= 6'h00;
      {n, etmr, ptmr, sdly, swin, log_n} <= '0;
    end else begin
      we_q <= flash_we_b;
      acc_q <= write_protect_accel_input;
      if (etmr != 0 && !esusp && swin == 0) etmr <= etmr - 1;
      if (swin != 0 && !esusp) swin <= swin - 1;
      if (etmr == 1 && !esusp) chip_on <= 1'b0;
      if (ptmr != 0 && !psusp) ptmr <= ptmr - 1;
      if (sdly == 1) esusp <= 1'b1;
      if (sdly != 0) sdly <= sdly - 1;
      if (sect_erase_go) begin
        etmr <= SE_CYC;
        swin <= SW_CYC;
      end
      if (write_protect_accel_input && !acc_q) byp <= 1'b1;
      if (!write_protect_accel_input && acc_q) byp <= 1'b0;
      if (flash_we_b && !we_q) begin
        log_a[log_n % 16] <= flash_addr;
        log_d[log_n % 16] <= d;
        log_n <= log_n + 1;
        n <= 0;
        x1 <= 1'b0;
        setup <= 1'b0;
        if (chip_on) n <= 0;
        else if (d == 16'h00B0 && prog_busy) psusp <= 1'b1;
        else if (d == 16'h00B0 && erase_busy && swin != 0) begin
          esusp <= 1'b1;
          swin <= 0;
        end
        else if (d == 16'h00B0 && erase_busy && sdly == 0)
          sdly <= SU_CYC;
        else if (d == 16'h0030 && psusp) psusp <= 1'b0;
        else if (d == 16'h0030 && esusp) esusp <= 1'b0;
        else if (setup) ptmr <= PG_CYC;
        else if (byp && d == 16'h00A0) setup <= 1'b1;
        else if (byp && d == 16'h0090) x1 <= 1'b1;
        else if (x1 && d == 16'h0000) byp <= 1'b0;
        else if ((n == 0 || n == 3) && a == u1 && d == 16'h00AA) n <= n + 1;
        else if ((n == 1 || n == 4) && a == u2 && d == 16'h0055) n <= n + 1;
        else if (n == 2 && a == u1 && d == 16'h0080 && !byp) n <= 3;
        else if (n == 2 && a == u1 && d == 16'h0020 && !byp)
          byp <= 1'b1;
        else if (n == 5 && a == u1 && d == 16'h0010) begin
          chip_on <= 1'b1;
          etmr <= CE_CYC;
        end
        // anything else, the reset data too, drops the sequence
        // unlock writes under suspend leave it standing
      end
    end
  end
endmodule : fesb_flash_model

// >>> test/tb_fesb_host.sv
// Purpose: self-checking bench for the flash command sequencer
// Assumes: device model on the far side of the flash bus
// Notes: bus writes are judged from the model's write ring
`timescale 1ns/1ps
module tb_fesb_host;
  // ****************************************************************
  // harness
  // ****************************************************************
  logic sys_clk = 0, rst_b = 0, cmd_valid = 0, byte_mode = 0;
  logic accel_req = 0, go = 0;
  logic [3:0] cmd_code = 0;
  logic [23:0] cmd_addr = 0, flash_addr;
  logic [15:0] cmd_data = 0, flash_dq_out;
  logic cmd_ready, cmd_refused, flash_dq_oe, flash_we_b, wpa, bypass_mode;
  logic erase_suspended, prog_suspended, chip_erase_on, erase_busy, prog_busy;
  int num_errors = 0, samples_checked = 0, base;
  always #5 sys_clk = ~sys_clk;
  fesb_host fesb_host_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .byte_mode(byte_mode), .accel_req(accel_req),
    .erase_busy(erase_busy), .prog_busy(prog_busy), .cmd_ready(cmd_ready),
    .cmd_refused(cmd_refused), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_we_b(flash_we_b), .write_protect_accel_input(wpa),
    .bypass_mode(bypass_mode), .erase_suspended(erase_suspended),
    .prog_suspended(prog_suspended), .chip_erase_on(chip_erase_on));
  fesb_flash_model fesb_flash_model_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_we_b(flash_we_b), .write_protect_accel_input(wpa),
    .byte_mode(byte_mode), .sect_erase_go(go), .erase_busy(erase_busy),
    .prog_busy(prog_busy));
  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic cyc(int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic wd(int k, logic [15:0] d);
    chk("write data", d, fesb_flash_model_i.log_d[(base + k) % 16]);
  endtask : wd
  task automatic wr(int k, logic [11:0] a, logic [15:0] d);
    chk("write addr", a, fesb_flash_model_i.log_a[(base + k) % 16][11:0]);
    wd(k, d);
  endtask : wr
  // one request, then wait for idle and judge the refusal pulse
  task automatic issue(logic [3:0] c, logic [23:0] a, logic [15:0] d,
                       logic ref_e);
    int i;
    logic seen;
    seen = 0;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) cyc(1);
    base = fesb_flash_model_i.log_n;
    cmd_code = c;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1;
    cyc(1);
    cmd_valid = 0;
    for (i = 0; i < 3; i++) begin
      if (cmd_refused === 1'b1) seen = 1;
      cyc(1);
    end
    for (i = 0; i < 200 && cmd_ready !== 1'b1; i++) cyc(1);
    cyc(2);
    chk("refused", ref_e, seen);
  endtask : issue
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_chip();
    logic [11:0] ea [6] = '{12'h555, 12'h2AA, 12'h555, 12'h555, 12'h2AA,
                            12'h555};
    logic [15:0] ed [6] = '{16'h00AA, 16'h0055, 16'h0080, 16'h00AA,
                            16'h0055, 16'h0010};
    issue(fesb_pkg::FESB_CMD_CHIP_ERASE, 0, 0, 0);
    for (int k = 0; k < 6; k++) wr(k, ea[k], ed[k]);
    chk("chip erase on", 1, chip_erase_on);
    issue(fesb_pkg::FESB_CMD_ERS_SUSP, 0, 0, 1);
    issue(fesb_pkg::FESB_CMD_BYP_ENTER, 0, 0, 1);
    cyc(400);
    chk("chip erase done", 0, chip_erase_on);
  endtask : t_chip
  task automatic t_abort();
    issue(fesb_pkg::FESB_CMD_CHIP_ERASE, 0, 0, 0);
    chk("abort erase on", 1, chip_erase_on);
    rst_b = 0;
    cyc(2);
    chk("abort erase off", 0, chip_erase_on);
    chk("abort busy off", 0, erase_busy);
    rst_b = 1;
    cyc(2);
    chk("ready after reset", 1, cmd_ready);
  endtask : t_abort
  task automatic t_esusp();
    go = 1;
    cyc(1);
    go = 0;
    cyc(10);
    issue(fesb_pkg::FESB_CMD_PGM_SUSP, 0, 0, 1);
    issue(fesb_pkg::FESB_CMD_ERS_SUSP, 24'h00ABCD, 0, 0);
    wd(0, 16'h00B0);
    chk("erase suspended", 1, erase_suspended);
    chk("window suspend", 0, erase_busy);
    issue(fesb_pkg::FESB_CMD_ERS_SUSP, 0, 0, 1);
    issue(fesb_pkg::FESB_CMD_ERS_RESUME, 0, 0, 0);
    wd(0, 16'h0030);
    chk("erase resumed", 0, erase_suspended);
    chk("erase running", 1, erase_busy);
    issue(fesb_pkg::FESB_CMD_ERS_RESUME, 0, 0, 1);
    issue(fesb_pkg::FESB_CMD_ERS_SUSP, 0, 0, 0);
    cyc(200);
    chk("erase busy", 0, erase_busy);
    issue(fesb_pkg::FESB_CMD_ERS_RESUME, 0, 0, 0);
    cyc(1600);
    chk("erase finished", 0, erase_busy);
  endtask : t_esusp
  task automatic t_bypass();
    logic [23:0] pa;
    byte_mode = 1;
    issue(fesb_pkg::FESB_CMD_BYP_PGM, 0, 0, 1);
    issue(fesb_pkg::FESB_CMD_BYP_ENTER, 0, 0, 0);
    wr(0, 12'hAAA, 16'h00AA);
    wr(1, 12'h555, 16'h0055);
    wr(2, 12'hAAA, 16'h0020);
    chk("bypass", 1, bypass_mode);
    chk("device bypass", 1, fesb_flash_model_i.byp);
    issue(fesb_pkg::FESB_CMD_BYP_ENTER, 0, 0, 1);
    issue(fesb_pkg::FESB_CMD_BYP_PGM, 24'h012345, 16'hBEEF, 0);
    wd(0, 16'h00A0);
    pa = fesb_flash_model_i.log_a[(base + 1) % 16];
    chk("program addr", 24'h012345, pa);
    wd(1, 16'hBEEF);
    issue(fesb_pkg::FESB_CMD_PGM_SUSP, 0, 0, 0);
    wd(0, 16'h00B0);
    chk("prog suspended", 1, prog_suspended);
    chk("prog halted", 0, prog_busy);
    issue(fesb_pkg::FESB_CMD_PGM_SUSP, 0, 0, 1);
    issue(fesb_pkg::FESB_CMD_PGM_RESUME, 0, 0, 0);
    wd(0, 16'h0030);
    chk("prog resumed", 0, prog_suspended);
    chk("prog running", 1, prog_busy);
    issue(fesb_pkg::FESB_CMD_PGM_RESUME, 0, 0, 1);
    issue(fesb_pkg::FESB_CMD_RESET3, 0, 0, 0);
    wr(0, 12'hAAA, 16'h00AA);
    wr(1, 12'h555, 16'h0055);
    wr(2, 12'hAAA, 16'h00F0);
    chk("bypass kept", 1, fesb_flash_model_i.byp);
    issue(fesb_pkg::FESB_CMD_BYP_EXIT, 0, 0, 0);
    wd(0, 16'h0090);
    wd(1, 16'h0000);
    chk("bypass exit", 0, bypass_mode);
    chk("device exit", 0, fesb_flash_model_i.byp);
    byte_mode = 0;
  endtask : t_bypass
  task automatic t_accel();
    accel_req = 1;
    cyc(20);
    chk("accel pin", 1, wpa);
    chk("accel bypass", 1, bypass_mode);
    issue(fesb_pkg::FESB_CMD_BYP_EXIT, 0, 0, 1);
    accel_req = 0;
    cyc(20);
    chk("accel off", 0, wpa);
    chk("accel bypass off", 0, bypass_mode);
    for (int k = 0; k < 9; k++) begin
      accel_req = 1;
      cyc(6);
      accel_req = 0;
      cyc(6);
    end
    accel_req = 1;
    cyc(20);
    chk("accel limit", 0, wpa);
    chk("accel limit bypass", 0, bypass_mode);
    accel_req = 0;
    cyc(6);
  endtask : t_accel
  task automatic finish_test();
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // main sequence and watchdog
  initial begin
    cyc(20);
    rst_b = 1;
    cyc(3);
    t_chip();
    t_abort();
    t_esusp();
    t_bypass();
    t_accel();
    finish_test();
  end
  initial begin
    #300000;
    num_errors++;
    finish_test();
  end
endmodule : tb_fesb_host
